// [rps_map.svh]
// Register offsets, field positions, reset values and counts of the ready pulse block
`ifndef RPS_MAP_SVH
`define RPS_MAP_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define RPS_OFF_CTRL 8'h00
`define RPS_OFF_STATUS 8'h04
`define RPS_OFF_IRQ_EN 8'h08
`define RPS_OFF_IRQ_CLR 8'h0C
`define RPS_OFF_COUNT 8'h10
// ****************************************************************
// Control register fields
// ****************************************************************
`define RPS_CTRL_DRIVE 0
`define RPS_CTRL_EXTCLK 1
`define RPS_CTRL_EXTREF 2
`define RPS_CTRL_PRE_LO 3
`define RPS_CTRL_PRE_HI 4
`define RPS_CTRL_OSR_LO 5
`define RPS_CTRL_OSR_HI 7
`define RPS_CTRL_RST 8'h00
// ****************************************************************
// Event bits and counts
// ****************************************************************
`define RPS_EVT_START 0
`define RPS_EVT_END 1
`define RPS_OSR_MIN 32
`define RPS_SAMPLE_DIV 4
`define RPS_QUARTER_LAST 2'h3
`define RPS_PULSE_LAST 2'h1
`endif

// [rps_pkg.sv]
// Types shared by the ready pulse block
package rps_pkg;
    typedef logic [31:0] rps_word_t;
    typedef logic [7:0] rps_addr_t;
    typedef logic [1:0] rps_pre_t;
    typedef logic [2:0] rps_osr_t;
    typedef enum logic {RPS_IDLE, RPS_PULSE} rps_pulse_t;
endpackage

// [rps_if.sv]
// Link between the control top and the clock divider chain
interface rps_if #(parameter int CNT_W = 12);
    logic master_tick;
    rps_pkg::rps_pre_t prescale_sel;
    rps_pkg::rps_osr_t ratio_sel;
    logic ready_start;
    logic ready_end;
    logic ready_active;
    logic [CNT_W-1:0] sample_count;
    modport ctl (output master_tick, prescale_sel, ratio_sel,
                 input ready_start, ready_end, ready_active, sample_count);
    modport div (input master_tick, prescale_sel, ratio_sel,
                 output ready_start, ready_end, ready_active, sample_count);
endinterface

// [rps_divider.sv]
// Prescaler, divide by four and ratio counter that time the ready pulse
`include "rps_map.svh"
module rps_divider #(parameter int CNT_W = 12) (
    input wire logic clk,
    input wire logic reset_n,
    rps_if.div lnk
);
    import rps_pkg::*;
    logic [2:0] pre_cnt, next_pre_cnt, pre_last;
    logic [1:0] quarter, next_quarter;
    logic [CNT_W-1:0] ratio_cnt, next_ratio_cnt, ratio_last;
    rps_pulse_t state, next_state;
    logic analog_core_clock_tick, sample_tick, wrap;

    // Counter must hold the largest ratio
    if (CNT_W < 12) begin : g_chk
        $error("rps_divider: CNT_W below 12 cannot count a ratio of 4096");
    end

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        pre_last = 3'((4'h1 << lnk.prescale_sel) - 4'h1);
        ratio_last = CNT_W'((`RPS_OSR_MIN << lnk.ratio_sel) - 1);
        // Greater-or-equal so a smaller setting never strands a count
        analog_core_clock_tick = lnk.master_tick && (pre_cnt >= pre_last);          // see R12 R13
        sample_tick = analog_core_clock_tick && (quarter == `RPS_QUARTER_LAST);     // see R14
        wrap = sample_tick && (ratio_cnt >= ratio_last);                // see R15 R16
        next_pre_cnt = pre_cnt;
        if (lnk.master_tick) begin
            next_pre_cnt = analog_core_clock_tick ? 3'h0 : 3'(pre_cnt + 3'h1);
        end
        next_quarter = analog_core_clock_tick ? 2'(quarter + 2'h1) : quarter;
        next_ratio_cnt = ratio_cnt;
        if (sample_tick) begin
            next_ratio_cnt = wrap ? '0 : CNT_W'(ratio_cnt + 1'b1);
        end
        next_state = state;
        case (state)
            RPS_IDLE: begin
                if (wrap) begin
                    next_state = RPS_PULSE;                             // see R2 R4
                end
            end
            RPS_PULSE: begin
                // Two analog ticks: half a sample period
                if (analog_core_clock_tick && quarter == `RPS_PULSE_LAST) begin
                    next_state = RPS_IDLE;                              // see R3 R5
                end
            end
            default: next_state = RPS_IDLE;
        endcase
    end

    // Register the chain
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_cnt <= 3'h0;
            quarter <= 2'h0;
            ratio_cnt <= '0;
            state <= RPS_IDLE;                                          // see R16
        end else begin
            pre_cnt <= next_pre_cnt;
            quarter <= next_quarter;
            ratio_cnt <= next_ratio_cnt;
            state <= next_state;
        end
    end

    // Results toward the top
    assign lnk.ready_start = wrap;
    assign lnk.ready_end = (state == RPS_PULSE) && (next_state == RPS_IDLE);
    assign lnk.ready_active = (state == RPS_PULSE);
    assign lnk.sample_count = ratio_cnt;
endmodule // rps_divider

// [rps_top.sv]
// Ready pulse generator with clock source, prescale and reference selection
// Operation
// R1: Idle ready pin driven high when drive select set, else released; released at reset.
// R2: Every finished conversion gives one low pulse on the ready pin.
// R3: Low pulse lasts exactly half of one sample clock period.
// R4: Pulses repeat once per output rate clock period.
// R5: Pulse timed from the master clock with a fixed unchanging width.
// R6: Pulse is never latched and ignores host reads or serial activity.
// R7: Width and period depend only on master clock, ratio and prescale.
// R8: External clock select stops the oscillator and uses the input pin directly.
// R9: Clock select clear, the default, runs the crystal oscillator.
// R10: External reference select disables the internal reference.
// R11: Reference select clear, the default, enables internal reference and its switch.
// R12: Analog core clock is the master clock divided by the prescale factor.
// R13: Prescale code 00,01,10,11 divides by 1,2,4,8; default 1.
// R14: Sample clock is the analog core clock divided by four.
// R15: Output rate clock is the sample clock divided by the ratio.
// R16: Ratio counter wraps to start the pulse; reset clears it and idles.
//
// Local design decisions: the register addresses and the APB register port.
`include "rps_map.svh"
module rps_top #(parameter int CNT_W = 12) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input rps_pkg::rps_addr_t PADDR,
    input rps_pkg::rps_word_t PWDATA,
    output rps_pkg::rps_word_t PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic OSC_IN,
    output logic OSC_OUT,
    output logic OSC_AMP_EN,
    output logic REF_INT_EN,
    output logic REF_SWITCH_ON,
    output logic DATA_READY_N_O,
    output logic DATA_READY_N_OE,
    output logic IRQ
);
    import rps_pkg::*;

    localparam int EVT_W = 2;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    // Control register and its decoded fields
    logic [7:0] ctrl, next_ctrl;
    logic drive_sel;
    logic ext_clock_sel;
    logic ext_reference_sel;
    rps_pre_t analog_core_clock_divider_sel;
    rps_osr_t decimation_ratio;

    // Interrupt state
    logic [EVT_W-1:0] status, next_status;
    logic [EVT_W-1:0] irq_en, next_irq_en;
    logic [EVT_W-1:0] event_hit;
    logic [EVT_W-1:0] clear_hit;

    // Bus state
    logic next_pready;
    logic next_pslverr;
    rps_word_t next_prdata;
    logic access;
    logic wr_take;
    logic addr_ok;

    // Clock source state
    logic osc_prev, next_osc_prev;
    logic master_tick;

    // Pin state
    logic next_ready_n_o;
    logic next_ready_n_oe;
    logic next_irq;
    logic next_osc_out;
    logic next_osc_amp_en;
    logic next_ref_int_en;
    logic next_ref_switch_on;

    rps_if #(.CNT_W(CNT_W)) lnk ();

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // Word address match, used by both read and write decode
    function automatic logic reg_hit(input rps_addr_t addr, input rps_addr_t off);
        reg_hit = (addr[7:2] == off[7:2]);
    endfunction

    // Map a register address to whether it exists
    function automatic logic reg_known(input rps_addr_t addr);
        reg_known = reg_hit(addr, `RPS_OFF_CTRL) || reg_hit(addr, `RPS_OFF_STATUS) ||
                    reg_hit(addr, `RPS_OFF_IRQ_EN) || reg_hit(addr, `RPS_OFF_IRQ_CLR) ||
                    reg_hit(addr, `RPS_OFF_COUNT);
    endfunction

    // ****************************************************************
    // Field decode
    // ****************************************************************
    // Control fields steer the clock chain and the pins
    assign drive_sel = ctrl[`RPS_CTRL_DRIVE];
    assign ext_clock_sel = ctrl[`RPS_CTRL_EXTCLK];
    assign ext_reference_sel = ctrl[`RPS_CTRL_EXTREF];
    assign analog_core_clock_divider_sel = ctrl[`RPS_CTRL_PRE_HI:`RPS_CTRL_PRE_LO];
    assign decimation_ratio = ctrl[`RPS_CTRL_OSR_HI:`RPS_CTRL_OSR_LO];

    // ****************************************************************
    // Master clock source
    // ****************************************************************
    // Crystal mode ticks every cycle; external mode ticks on pin rising edges
    always_comb begin
        next_osc_prev = OSC_IN;
        if (ext_clock_sel) begin
            master_tick = OSC_IN && !osc_prev;                          // see R8
        end else begin
            master_tick = 1'b1;                                         // see R9
        end
    end

    // Previous pin level for edge detection
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            osc_prev <= 1'b0;
        end else begin
            osc_prev <= next_osc_prev;
        end
    end

    // ****************************************************************
    // Divider chain
    // ****************************************************************
    // Only the clock source and the two divide settings reach the chain
    assign lnk.master_tick = master_tick;                               // see R7
    assign lnk.prescale_sel = analog_core_clock_divider_sel;                        // see R12
    assign lnk.ratio_sel = decimation_ratio;                            // see R15

    rps_divider #(.CNT_W(CNT_W)) u_div (
        .clk(CLK),
        .reset_n(RESET_N),
        .lnk(lnk.div)
    );

    // ****************************************************************
    // APB slave
    // ****************************************************************
    // Answer one cycle into the access phase; unmapped words raise PSLVERR
    always_comb begin
        access = PSEL && PENABLE;
        wr_take = access && PREADY && PWRITE;
        addr_ok = reg_known(PADDR);
        next_pready = access && !PREADY;
        next_pslverr = access && !PREADY && !addr_ok;
        next_prdata = '0;
        if (access && !PREADY && !PWRITE) begin
            if (reg_hit(PADDR, `RPS_OFF_CTRL)) begin
                next_prdata = {24'h000000, ctrl};
            end else if (reg_hit(PADDR, `RPS_OFF_STATUS)) begin
                next_prdata = {30'h0, status};
            end else if (reg_hit(PADDR, `RPS_OFF_IRQ_EN)) begin
                next_prdata = {30'h0, irq_en};
            end else if (reg_hit(PADDR, `RPS_OFF_COUNT)) begin
                // Counter value and pulse phase show the chain's own state
                // Counter field is twelve bits wide whatever CNT_W is
                next_prdata = {15'h0, lnk.ready_active, 4'h0, 12'(lnk.sample_count)};
            end else begin
                next_prdata = '0;
            end
        end
    end

    // Bus answer registers
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h00000000;
        end else begin
            PREADY <= next_pready;
            PSLVERR <= next_pslverr;
            PRDATA <= next_prdata;
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    // Writes land at the edge that completes the access
    always_comb begin
        next_ctrl = ctrl;
        next_irq_en = irq_en;
        if (wr_take && reg_hit(PADDR, `RPS_OFF_CTRL)) begin
            next_ctrl = PWDATA[7:0];
        end
        if (wr_take && reg_hit(PADDR, `RPS_OFF_IRQ_EN)) begin
            next_irq_en = PWDATA[EVT_W-1:0];
        end
    end

    // Configuration flops; reset leaves every select at its default
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl <= `RPS_CTRL_RST;                                      // see R1 R9 R11 R13
            irq_en <= '0;
        end else begin
            ctrl <= next_ctrl;
            irq_en <= next_irq_en;
        end
    end

    // ****************************************************************
    // Interrupt status
    // ****************************************************************
    // Events from the chain and write-one-to-clear requests
    always_comb begin
        event_hit = '0;
        event_hit[`RPS_EVT_START] = lnk.ready_start;
        event_hit[`RPS_EVT_END] = lnk.ready_end;
        clear_hit = '0;
        if (wr_take && reg_hit(PADDR, `RPS_OFF_IRQ_CLR)) begin
            clear_hit = PWDATA[EVT_W-1:0];
        end
    end

    // Sticky bits; a new event beats a clear in the same cycle
    for (genvar i = 0; i < EVT_W; i++) begin : g_evt
        always_comb begin
            if (event_hit[i]) begin
                next_status[i] = 1'b1;
            end else if (clear_hit[i]) begin
                next_status[i] = 1'b0;
            end else begin
                next_status[i] = status[i];
            end
        end
    end

    // Status flops
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    // Ready pin level follows the chain alone, never a bus access; drive select also sets its idle drive
    always_comb begin
        next_ready_n_o = !lnk.ready_active;                             // see R2 R6
        // Low pulse always driven; idle high only when drive select set
        next_ready_n_oe = drive_sel || lnk.ready_active;                // see R1
        next_irq = |(status & irq_en);
        // Oscillator amplifier runs only in crystal mode
        next_osc_amp_en = !ext_clock_sel;                               // see R8 R9
        next_osc_out = !ext_clock_sel && !OSC_IN;                       // see R9
        next_ref_int_en = !ext_reference_sel;                           // see R10 R11
        next_ref_switch_on = !ext_reference_sel;                        // see R11
    end

    // Output flops; ready pin released and high during reset
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            DATA_READY_N_O <= 1'b1;
            DATA_READY_N_OE <= 1'b0;                                    // see R16
            IRQ <= 1'b0;
            OSC_AMP_EN <= 1'b1;
            OSC_OUT <= 1'b0;
            REF_INT_EN <= 1'b1;
            REF_SWITCH_ON <= 1'b1;
        end else begin
            DATA_READY_N_O <= next_ready_n_o;
            DATA_READY_N_OE <= next_ready_n_oe;
            IRQ <= next_irq;
            OSC_AMP_EN <= next_osc_amp_en;
            OSC_OUT <= next_osc_out;
            REF_INT_EN <= next_ref_int_en;
            REF_SWITCH_ON <= next_ref_switch_on;
        end
    end
endmodule // rps_top

// [rps_props.sv]
// Concurrent checks on the ports of the ready pulse block
module rps_props
import rps_pkg::*;
#(parameter int CNT_W = 12) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input rps_pkg::rps_addr_t PADDR,
    input rps_pkg::rps_word_t PWDATA,
    input wire logic PREADY,
    input wire logic OSC_IN,
    input wire logic OSC_OUT,
    input wire logic OSC_AMP_EN,
    input wire logic REF_INT_EN,
    input wire logic REF_SWITCH_ON,
    input wire logic DATA_READY_N_O,
    input wire logic DATA_READY_N_OE
);
    // ****************************************************************
    // Shadow of the control word and pulse timers
    // ****************************************************************
    logic [7:0] ctrl, next_ctrl;
    logic [17:0] settle, next_settle, gap, next_gap, low_cnt, next_low_cnt;
    logic prev_o, next_prev_o, wr_ctrl, fall, rise;
    assign wr_ctrl = PSEL & PENABLE & PREADY & PWRITE & (PADDR[7:2] == 6'h00);
    assign fall = prev_o & ~DATA_READY_N_O;
    assign rise = ~prev_o & DATA_READY_N_O;
    // Settle counts cycles since the last control write, so live changes are skipped
    always_comb begin
        next_ctrl = wr_ctrl ? PWDATA[7:0] : ctrl;
        next_settle = wr_ctrl ? 18'h0 : ((&settle) ? settle : settle + 18'h1);
        next_gap = fall ? 18'h1 : ((&gap) ? gap : gap + 18'h1);
        next_low_cnt = DATA_READY_N_O ? 18'h0 : low_cnt + 18'h1;
        next_prev_o = DATA_READY_N_O;
    end
    // Registers of the helper state
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl <= 8'h00;
            settle <= 18'h0;
            gap <= 18'h0;
            low_cnt <= 18'h0;
            prev_o <= 1'b1;
        end else begin
            ctrl <= next_ctrl;
            settle <= next_settle;
            gap <= next_gap;
            low_cnt <= next_low_cnt;
            prev_o <= next_prev_o;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_OE_LOW: assert property (!DATA_READY_N_O |-> DATA_READY_N_OE)
        else $error("ready pin low while not driven");
    AST_IDLE_HIZ: assert property (DATA_READY_N_O && !ctrl[0] && settle > 2 |-> !DATA_READY_N_OE)
        else $error("idle ready pin driven with drive select clear");
    AST_IDLE_DRIVE: assert property (ctrl[0] && settle > 2 |-> DATA_READY_N_OE)
        else $error("idle ready pin released with drive select set");
    AST_WIDTH: assert property (rise && !ctrl[1] && settle > low_cnt + 2 |-> low_cnt == (2 << ctrl[4:3]))
        else $error("ready pulse width wrong");
    AST_PERIOD: assert property (fall && !ctrl[1] && settle > gap + 3 |-> gap == ((128 << ctrl[4:3]) << ctrl[7:5]))
        else $error("ready pulse period wrong");
    AST_OSC_RUN: assert property (OSC_AMP_EN && $past(OSC_AMP_EN) && settle > 2 |-> OSC_OUT == !$past(OSC_IN))
        else $error("oscillator output does not follow input");
    AST_OSC_OFF: assert property (!OSC_AMP_EN && !$past(OSC_AMP_EN) |-> !OSC_OUT)
        else $error("oscillator output active in external clock mode");
    AST_AMP: assert property (settle > 2 |-> OSC_AMP_EN == !ctrl[1])
        else $error("oscillator enable does not match clock select");
    AST_REF: assert property (settle > 2 |-> REF_INT_EN == !ctrl[2] && REF_SWITCH_ON == !ctrl[2])
        else $error("reference enable does not match reference select");
endmodule // rps_props

// [rps_partner.sv]
// Far side model: external clock source and pulled-up interrupt input
module rps_partner (
    input wire logic clk,
    input wire logic [3:0] half,
    input wire logic drv_o,
    input wire logic drv_oe,
    output logic osc_in,
    output logic pin,
    output int falls
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt = 4'h0;
    logic last = 1'b1;
    initial osc_in = 1'b0;
    initial falls = 0;
    // Pull-up holds the released ready line high
    assign pin = drv_oe ? drv_o : 1'b1;
    // Free running clock source synchronous to clk, and edge counter of the interrupt input
    always @(posedge clk) begin
        if (cnt >= half - 4'h1) begin
            cnt <= 4'h0;
            osc_in <= ~osc_in;
        end else begin
            cnt <= cnt + 4'h1;
        end
        last <= pin;
        if (last && !pin) begin
            falls <= falls + 1;
        end
    end
endmodule // rps_partner

// [rps_top_test.sv]
// Self-checking bench of the ready pulse block
`include "rps_map.svh"
module rps_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import rps_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    rps_addr_t paddr = 8'h00;
    rps_word_t pwdata = 32'h0;
    rps_word_t prdata, rdata;
    logic pready, pslverr, osc_in, osc_out, amp_en, ref_en, ref_sw, dr_o, dr_oe, irq, pin, rerr;
    int falls, w, p;
    int bad_count = 0;
    int n_tests = 0;
    rps_top #(.CNT_W(12)) dut (.CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .OSC_IN(osc_in),
        .OSC_OUT(osc_out), .OSC_AMP_EN(amp_en), .REF_INT_EN(ref_en), .REF_SWITCH_ON(ref_sw),
        .DATA_READY_N_O(dr_o), .DATA_READY_N_OE(dr_oe), .IRQ(irq));
    rps_partner u_far (.clk(clk), .half(4'h2), .drv_o(dr_o), .drv_oe(dr_oe), .osc_in(osc_in), .pin(pin),
        .falls(falls));
    // 25 MHz clock
    initial forever #20 clk = ~clk;
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task end_sim;
        $display("mismatches %0d of %0d comparisons", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask
    task tick(inout int n);
        @(posedge clk);
        n++;
        if (n > 20000) begin
            $display("unexpected wait expected handshake seen none");
            bad_count++;
            end_sim;
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task apb(input logic wr, input rps_addr_t a, input rps_word_t d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do tick(n); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input rps_addr_t a, input rps_word_t exp);
        apb(1'b0, a, 32'h0);
        chk("read error", 0, rerr);
        chk("read data", exp, rdata);
    endtask
    // Low width and fall-to-fall period of one pulse on the pulled-up line
    task measure;
        int n;
        n = 0;
        while (pin !== 1'b1) tick(n);
        while (pin !== 1'b0) tick(n);
        w = 0;
        while (pin === 1'b0) begin
            tick(n);
            w++;
        end
        p = w;
        while (pin !== 1'b0) begin
            tick(n);
            p++;
        end
    endtask
    // Bound on the whole run
    initial begin
        repeat (90000) @(posedge clk);
        bad_count++;
        end_sim;
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        int pre, code, n;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chk("idle oe", 0, dr_oe);
        chk("amp en", 1, amp_en);
        chk("reference", 2'b11, {ref_en, ref_sw});
        rd(`RPS_OFF_CTRL, `RPS_CTRL_RST);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped error", 1, rerr);
        chk("unmapped data", 0, rdata);
        // Every prescale code at the smallest ratio, then the next ratio
        for (int i = 0; i < 5; i++) begin
            pre = (i < 4) ? i : 0;
            code = (i < 4) ? 0 : 1;
            apb(1'b1, `RPS_OFF_CTRL, 32'(code * 32 + pre * 8));
            measure;
            measure;
            chk("low width", 2 << pre, w);
            chk("period", 128 << (pre + code), p);
        end
        apb(1'b1, `RPS_OFF_CTRL, 32'h01);
        measure;
        repeat (3) @(posedge clk);
        chk("driven idle", 2'b11, {dr_oe, dr_o});
        // Interrupt raised, read, cleared, then masked
        apb(1'b1, `RPS_OFF_IRQ_EN, 32'h1);
        measure;
        repeat (3) @(posedge clk);
        chk("irq raised", 1, irq);
        rd(`RPS_OFF_STATUS, 32'h3);
        apb(1'b1, `RPS_OFF_IRQ_CLR, 32'h3);
        repeat (2) @(posedge clk);
        chk("irq cleared", 0, irq);
        apb(1'b1, `RPS_OFF_IRQ_EN, 32'h0);
        measure;
        chk("irq masked", 0, irq);
        rd(`RPS_OFF_IRQ_CLR, 32'h0);
        // External clock of four cycles and external reference
        apb(1'b1, `RPS_OFF_CTRL, 32'h06);
        measure;
        measure;
        chk("ext width", 8, w);
        chk("ext period", 512, p);
        chk("osc off", 2'b00, {amp_en, osc_out});
        chk("ext reference", 2'b00, {ref_en, ref_sw});
        // Reset in the middle of a pulse
        measure;
        n = 0;
        while (pin !== 1'b0) tick(n);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk("reset pin", 1, pin);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(`RPS_OFF_CTRL, 32'h0);
        measure;
        measure;
        chk("after reset", 130, w + p);
        // One sample counted since the wrap, pulse already over
        rd(`RPS_OFF_COUNT, 32'h1);
        chk("pulses seen", 1, falls > 10);
        end_sim;
    end
endmodule // rps_top_test
bind rps_top rps_props #(.CNT_W(CNT_W)) u_props (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .OSC_IN(OSC_IN), .OSC_OUT(OSC_OUT),
    .OSC_AMP_EN(OSC_AMP_EN), .REF_INT_EN(REF_INT_EN), .REF_SWITCH_ON(REF_SWITCH_ON),
    .DATA_READY_N_O(DATA_READY_N_O), .DATA_READY_N_OE(DATA_READY_N_OE));
